// [rtl/comparator_irq_regs.vh]
// Register offsets, field codes and reset values of the comparator
// edge interrupt selection block; definitions only, no logic.
// Assumes the includer uses 6-bit register addresses.
// Functional notes
// RULE1 - Field value zero: no comparator interrupt for that input, ever.
// RULE2 - Field value one: interrupt only when level rises above group threshold.
// RULE3 - Field value two: interrupt only when level falls below group threshold.
// RULE4 - Field value three: interrupt on every threshold crossing, either direction.
// RULE5 - Inputs 20 to 23 compare against their shared group threshold.
// RULE6 - Inputs 16 to 19 compare against their shared group threshold.
// RULE7 - Inputs 8 to 11 compare against their shared group threshold.
// RULE8 - Inputs 4 to 7 compare against their shared group threshold.
// RULE9 - Inputs 0 to 3 compare against their shared group threshold.
// RULE10 - Low select register holds inputs 0 to 11, input n at bits 2n+1:2n.
// RULE11 - High select register at its own offset holds inputs 12 to 23.
// RULE12 - All select fields are host read/write and reset to zero.
// RULE13 - Group threshold code selects 2 V, 2.7 V, 3 V or 4 V.
// RULE14 - Crossing found by comparing each new sample with the previous one.
`ifndef COMPARATOR_IRQ_REGS_VH
`define COMPARATOR_IRQ_REGS_VH

`define REG_ADDR_W          6
`define REG_DATA_W          24
`define OFS_SELECT_LOW      6'h22
`define OFS_SELECT_HIGH     6'h23
`define SELECT_RESET        24'h000000

`define FIELD_W             2
`define SEL_NONE            2'h0
`define SEL_RISE            2'h1
`define SEL_FALL            2'h2
`define SEL_BOTH            2'h3

`define THR_CODE_2V0        2'h0
`define THR_CODE_2V7        2'h1
`define THR_CODE_3V0        2'h2
`define THR_CODE_4V0        2'h3

`define LEVEL_W             16
`define THR_2V0_MV          16'h07d0
`define THR_2V7_MV          16'h0a8c
`define THR_3V0_MV          16'h0bb8
`define THR_4V0_MV          16'h0fa0

`endif

// [rtl/threshold_compare.v]
// One group of four inputs judged against the group's threshold code.
// Assumes levels are millivolt samples from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
`include "comparator_irq_regs.vh"

module threshold_compare (
  input  wire [`FIELD_W-1:0]   setting,
  input  wire [4*`LEVEL_W-1:0] levels,
  output wire [3:0]            above
);

  reg [`LEVEL_W-1:0] ref_mv;

  always @* begin
    case (setting)
      `THR_CODE_2V0: ref_mv = `THR_2V0_MV; // RULE13
      `THR_CODE_2V7: ref_mv = `THR_2V7_MV; // RULE13
      `THR_CODE_3V0: ref_mv = `THR_3V0_MV; // RULE13
      `THR_CODE_4V0: ref_mv = `THR_4V0_MV; // RULE13
      default:       ref_mv = `THR_2V0_MV;
    endcase
  end

  genvar k;
  generate
    for (k = 0; k < 4; k = k + 1) begin : g_in
      // Equal to threshold counts as below, so a level parked on it never toggles
      assign above[k] = levels[k*`LEVEL_W +: `LEVEL_W] > ref_mv;
    end
  endgenerate

endmodule
`default_nettype wire

// [rtl/comparator_edge_interrupt_enable.v]
// Comparator edge interrupt selection for 24 switch inputs: two select
// registers, group threshold comparison and per-input edge events.
// Assumes the register port is driven by the device's serial frame decoder
// and the sense samples by the polling logic, both on core_clk.
`timescale 1ns/100ps
`default_nettype none
`include "comparator_irq_regs.vh"

module comparator_edge_interrupt_enable #(
  parameter NUM_INPUTS = 24,
  parameter NUM_GROUPS = 6
) (
  input  wire                         core_clk,
  input  wire                         rst,
  input  wire [`REG_ADDR_W-1:0]       reg_addr,
  input  wire [`REG_DATA_W-1:0]       reg_wdata,
  input  wire                         reg_write,
  input  wire                         reg_read,
  output reg  [`REG_DATA_W-1:0]       reg_rdata,
  output reg                          reg_rdata_valid,
  output reg                          reg_hit,
  input  wire [2*NUM_GROUPS-1:0]      group_threshold,
  input  wire                         sample_strobe,
  input  wire [NUM_INPUTS*`LEVEL_W-1:0] sense_level,
  output reg  [NUM_INPUTS-1:0]        comp_state,
  output reg                          comp_state_valid,
  output reg  [NUM_INPUTS-1:0]        comp_event,
  output reg                          comp_event_any
);

  localparam HALF = NUM_INPUTS / 2;

  // Select registers
  reg  [`REG_DATA_W-1:0]      comparator_irq_select_low;
  reg  [`REG_DATA_W-1:0]      comparator_irq_select_high;

  // Combined field vector, input n at bits 2n+1:2n
  wire [2*NUM_INPUTS-1:0]     select_all;

  // Comparator results of the sample now presented
  wire [NUM_INPUTS-1:0]       above_now;

  // Per-input event of the sample now presented
  wire [NUM_INPUTS-1:0]       hit;

  reg  [NUM_INPUTS-1:0]       next_event;
  reg  [`REG_DATA_W-1:0]      next_rdata;
  reg                         next_hit;

  // Field decode, shared by every input
  function edge_hit;
    input [`FIELD_W-1:0] field;
    input                prev;
    input                now;
    begin
      case (field)
        `SEL_NONE: edge_hit = 1'b0;           // RULE1
        `SEL_RISE: edge_hit = ~prev & now;    // RULE2
        `SEL_FALL: edge_hit = prev & ~now;    // RULE3
        `SEL_BOTH: edge_hit = prev ^ now;     // RULE4
        default:   edge_hit = 1'b0;
      endcase
    end
  endfunction

  // Address decode, used by the read path for the hit flag; write strobes compare offsets directly
  function is_mapped;
    input [`REG_ADDR_W-1:0] addr;
    begin
      is_mapped = (addr == `OFS_SELECT_LOW) || (addr == `OFS_SELECT_HIGH);
    end
  endfunction

  // Low register carries the first HALF inputs, high register the rest;
  // each input picks its own pair, so the split is one parameter
  genvar s;
  generate
    for (s = 0; s < NUM_INPUTS; s = s + 1) begin : g_fld
      if (s < HALF) begin : g_low
        assign select_all[2*s +: 2] = comparator_irq_select_low[2*s +: 2]; // RULE10
      end else begin : g_high
        assign select_all[2*s +: 2] = comparator_irq_select_high[2*(s-HALF) +: 2]; // RULE11
      end
    end
  endgenerate

  genvar g;
  generate
    for (g = 0; g < NUM_GROUPS; g = g + 1) begin : g_grp
      // One threshold code per group of four inputs
      threshold_compare u_cmp (
        .setting (group_threshold[2*g +: 2]),             // RULE5 RULE6 RULE7 RULE8 RULE9
        .levels  (sense_level[g*4*`LEVEL_W +: 4*`LEVEL_W]),
        .above   (above_now[4*g +: 4])
      );
    end
  endgenerate

  genvar n;
  generate
    for (n = 0; n < NUM_INPUTS; n = n + 1) begin : g_in
      // Previous sample against new one
      assign hit[n] = edge_hit(select_all[2*n +: 2], comp_state[n], above_now[n]); // RULE14
    end
  endgenerate

  // Events are only judged once a previous sample exists;
  // the first sample after reset sets the reference silently.
  wire                        judge_now;
  reg  [NUM_INPUTS-1:0]       next_state;
  reg                         next_valid;

  assign judge_now = sample_strobe && comp_state_valid; // RULE14

  always @* begin
    next_event = {NUM_INPUTS{1'b0}};
    if (judge_now) begin
      next_event = hit; // RULE14
    end
  end

  // History moves only on a strobe, so idle cycles between polls
  // never overwrite the reference of the last real sample
  always @* begin
    next_state = comp_state;
    next_valid = comp_state_valid;
    if (sample_strobe) begin
      next_state = above_now; // RULE14
      next_valid = 1'b1;
    end
  end

  // Write strobes per register; unmapped offsets raise neither,
  // so a stray write can never disturb a select field
  wire                        write_low;
  wire                        write_high;

  assign write_low  = reg_write && (reg_addr == `OFS_SELECT_LOW);  // RULE10
  assign write_high = reg_write && (reg_addr == `OFS_SELECT_HIGH); // RULE11

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      comparator_irq_select_low <= `SELECT_RESET; // RULE12
    end else if (write_low) begin
      comparator_irq_select_low <= reg_wdata; // RULE12
    end
  end

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      comparator_irq_select_high <= `SELECT_RESET; // RULE12
    end else if (write_high) begin
      comparator_irq_select_high <= reg_wdata; // RULE12
    end
  end

  // Read mux; unmapped offsets read as zero. A read in the cycle
  // of a write to the same offset returns the old value.
  always @* begin
    next_rdata = {`REG_DATA_W{1'b0}};
    next_hit   = is_mapped(reg_addr);
    case (reg_addr)
      `OFS_SELECT_LOW:  next_rdata = comparator_irq_select_low;  // RULE12
      `OFS_SELECT_HIGH: next_rdata = comparator_irq_select_high; // RULE12
      default:          next_rdata = {`REG_DATA_W{1'b0}};
    endcase
  end

  // Read data held until the next read
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= {`REG_DATA_W{1'b0}};
    end else if (reg_read) begin
      reg_rdata <= next_rdata;
    end
  end

  // Hit flag kept apart from the data, so the host can tell an
  // all-zero select register from an unmapped offset
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_hit <= 1'b0;
    end else if (reg_read) begin
      reg_hit <= next_hit;
    end
  end

  // Valid pulse follows every read, mapped or not
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      reg_rdata_valid <= 1'b0;
    end else begin
      reg_rdata_valid <= reg_read;
    end
  end

  // Sample history; reset drops the reference, so the first
  // strobe after any reset raises no event
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      comp_state       <= {NUM_INPUTS{1'b0}};
      comp_state_valid <= 1'b0;
    end else begin
      comp_state       <= next_state;
      comp_state_valid <= next_valid;
    end
  end

  // Event pulses last one cycle; strobes every cycle give
  // back-to-back pulses, never merged into one
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      comp_event     <= {NUM_INPUTS{1'b0}};
      comp_event_any <= 1'b0;
    end else begin
      comp_event     <= next_event;
      comp_event_any <= |next_event;
    end
  end

  // A select change takes effect from the next sample; a pending
  // level difference is then judged by the new field, which trades
  // a possible late event for not keeping per-field history.

endmodule
`default_nettype wire

// [rtl/unused_placeholder_none.v]
// Empty compilation unit kept in the source list; holds no logic.
// Assumes nothing of its surroundings.
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

// [verif/comparator_edge_interrupt_enable_properties.sv]
// Port checker for the comparator edge interrupt block.
// Assumes the design header is on the include path; attached by bind.
`timescale 1ns/100ps
`default_nettype none
`include "comparator_irq_regs.vh"
module cei_props #(parameter NUM_INPUTS = 24) (
  input wire logic                  core_clk,
  input wire logic                  rst,
  input wire logic [5:0]            reg_addr,
  input wire logic [23:0]           reg_wdata,
  input wire logic                  reg_write,
  input wire logic                  reg_read,
  input wire logic [23:0]           reg_rdata,
  input wire logic                  reg_rdata_valid,
  input wire logic                  reg_hit,
  input wire logic                  sample_strobe,
  input wire logic [NUM_INPUTS-1:0] comp_state,
  input wire logic                  comp_state_valid,
  input wire logic [NUM_INPUTS-1:0] comp_event,
  input wire logic                  comp_event_any
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire mapped = reg_addr == `OFS_SELECT_LOW || reg_addr == `OFS_SELECT_HIGH;
  sequence wr_gap_rd;
    reg_write && mapped ##1 !reg_write ##1 reg_read && reg_addr == $past(reg_addr, 2);
  endsequence
  unmapped_read_a: assert property (reg_read && !mapped |=> !reg_hit && reg_rdata == 24'h000000) else $error("unmapped read not empty");
  mapped_read_a: assert property (reg_read && mapped |=> reg_hit) else $error("mapped read missed");
  rdata_valid_a: assert property (reg_rdata_valid == $past(reg_read)) else $error("read valid not one cycle after read");
  write_back_a: assert property (wr_gap_rd |=> reg_rdata == $past(reg_wdata, 3)) else $error("read back differs");
  state_hold_a: assert property (!sample_strobe |=> $stable(comp_state) && comp_event == 0) else $error("state moved without sample");
  event_edge_a: assert property (comp_event != 0 |-> $past(comp_state_valid) && (comp_event & ~(comp_state ^ $past(comp_state))) == 0) else $error("event without crossing");
  valid_set_a: assert property (sample_strobe |=> comp_state_valid) else $error("valid not set");
  event_any_a: assert property (comp_event_any == (comp_event != 0)) else $error("any flag mismatch");
  event_pulse_a: assert property (comp_event_any && !$past(sample_strobe, 1) |-> 1'b0) else $error("event without strobe");
endmodule
bind comparator_edge_interrupt_enable cei_props #(.NUM_INPUTS(NUM_INPUTS)) u_props (
  .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
  .reg_rdata_valid(reg_rdata_valid), .reg_hit(reg_hit),
  .sample_strobe(sample_strobe), .comp_state(comp_state), .comp_state_valid(comp_state_valid),
  .comp_event(comp_event), .comp_event_any(comp_event_any));
`default_nettype wire

// [verif/host_model.sv]
// Host side model: one register request at a time on the register port.
// Assumes requests start just after a rising core_clk edge.
`timescale 1ns/100ps
`default_nettype none
module host_model (
  input  wire logic        core_clk,
  output var  logic [5:0]  reg_addr,
  output var  logic [23:0] reg_wdata,
  output var  logic        reg_write,
  output var  logic        reg_read,
  input  wire logic [23:0] reg_rdata,
  input  wire logic        reg_hit
);
  initial {reg_addr, reg_wdata, reg_write, reg_read} = 32'h0;
  task automatic xfer(input logic wr, input logic [5:0] a, input logic [23:0] d,
                      output logic [23:0] q, output logic h);
    @(posedge core_clk);
    {reg_write, reg_read, reg_addr, reg_wdata} <= {wr, !wr, a, d};
    @(posedge core_clk);
    // Released address and data lines show inverted values, strobes drop to zero, so stale data cannot pass
    {reg_write, reg_read, reg_addr, reg_wdata} <= {2'h0, ~a, ~d};
    #1;
    q = reg_rdata;
    h = reg_hit;
  endtask
endmodule
`default_nettype wire

// [verif/comparator_edge_interrupt_enable_test.sv]
// Bench for the comparator edge interrupt block: registers and sampling.
// Assumes the host model and the checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none
`include "comparator_irq_regs.vh"
module comparator_edge_interrupt_enable_test;
  logic         core_clk = 0, rst = 1, sample_strobe = 0, hit;
  logic [11:0]  group_threshold = 0;
  logic [383:0] sense_level = 0;
  logic [23:0]  comparator_irq_select_low, comparator_irq_select_high, q, st, ev, pst, r, r2;
  logic [31:0]  seed = 4;
  logic [15:0]  lv, th;
  logic [1:0]   f;
  wire  [5:0]   reg_addr;
  wire  [23:0]  reg_wdata, reg_rdata, comp_state, comp_event;
  wire          reg_write, reg_read, reg_rdata_valid, reg_hit, comp_state_valid, comp_event_any;
  int           num_errors = 0, tests_run = 0, i, n;
  always #5 core_clk = ~core_clk;
  host_model u_host (.core_clk(core_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_hit(reg_hit));
  comparator_edge_interrupt_enable u_dut (.core_clk(core_clk), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .reg_rdata_valid(reg_rdata_valid), .reg_hit(reg_hit),
    .group_threshold(group_threshold), .sample_strobe(sample_strobe),
    .sense_level(sense_level), .comp_state(comp_state), .comp_state_valid(comp_state_valid),
    .comp_event(comp_event), .comp_event_any(comp_event_any));
  function automatic logic [23:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[23:0];
  endfunction
  function automatic logic [15:0] thr_mv(input logic [1:0] c);
    return c == 0 ? `THR_2V0_MV : c == 1 ? `THR_2V7_MV : c == 2 ? `THR_3V0_MV : `THR_4V0_MV;
  endfunction
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #100000;
    num_errors++;
    give_verdict();
  end
  initial begin
    repeat (5) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("state valid reset", 24'h0, {23'h0, comp_state_valid});
    chk("rdata reset", 24'h0, reg_rdata);
    u_host.xfer(0, `OFS_SELECT_LOW, 24'h0, q, hit);
    chk("low reset", `SELECT_RESET, q);
    chk("read valid", 24'h1, {23'h0, reg_rdata_valid});
    u_host.xfer(0, `OFS_SELECT_HIGH, 24'h0, q, hit);
    chk("high reset", `SELECT_RESET, q);
    u_host.xfer(0, 6'h21, 24'h0, q, hit);
    chk("unmapped hit", 24'h0, {23'h0, hit});
    chk("unmapped data", 24'h0, q);
    $display("test reset values done");
    for (i = 0; i < 60; i++) begin
      comparator_irq_select_low = rnd();
      comparator_irq_select_high = rnd();
      // First passes sweep one mode over every input
      if (i < 4) begin
        comparator_irq_select_low = {12{i[1:0]}};
        comparator_irq_select_high = {12{i[1:0]}};
      end
      // The high write is read straight back, one idle cycle between
      u_host.xfer(1, `OFS_SELECT_LOW, comparator_irq_select_low, q, hit);
      u_host.xfer(1, 6'h24, rnd(), q, hit);
      u_host.xfer(1, `OFS_SELECT_HIGH, comparator_irq_select_high, q, hit);
      u_host.xfer(0, `OFS_SELECT_HIGH, 24'h0, q, hit);
      chk("high readback", comparator_irq_select_high, q);
      chk("high hit", 24'h1, {23'h0, hit});
      u_host.xfer(0, `OFS_SELECT_LOW, 24'h0, q, hit);
      chk("low readback", comparator_irq_select_low, q);
      r = rnd();
      @(posedge core_clk);
      group_threshold <= r[11:0];
      sample_strobe <= 1'b1;
      // Levels sit on the threshold, so equality is hit often
      for (n = 0; n < 24; n++) begin
        r2 = rnd();
        th = thr_mv(r[2*(n/4)+:2]);
        lv = th + {14'h0, r2[1:0]} - 16'h2;
        sense_level[16*n+:16] <= lv;
        st[n] = lv > th;
        f = n < 12 ? comparator_irq_select_low[2*n+:2] : comparator_irq_select_high[2*n-24+:2];
        ev[n] = i > 0 && (f[0] && !pst[n] && st[n] || f[1] && pst[n] && !st[n]);
      end
      @(posedge core_clk);
      sample_strobe <= 1'b0;
      #1;
      chk("state", st, comp_state);
      chk("events", ev, comp_event);
      chk("any", {23'h0, |ev}, {23'h0, comp_event_any});
      chk("state valid", 24'h1, {23'h0, comp_state_valid});
      pst = st;
    end
    $display("test sampling done");
    // Reset in mid-run clears the fields and the sample reference
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    #1;
    chk("valid cleared", 24'h0, {23'h0, comp_state_valid});
    chk("rdata cleared", 24'h0, reg_rdata);
    u_host.xfer(0, `OFS_SELECT_LOW, 24'h0, q, hit);
    chk("low cleared", `SELECT_RESET, q);
    u_host.xfer(0, `OFS_SELECT_HIGH, 24'h0, q, hit);
    chk("high cleared", `SELECT_RESET, q);
    $display("test mid reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
